/* bench/ctd_mem_model.sv */
// Internal data memory model seen by the decoder's read and write ports
`timescale 1ns/1ps
module ctd_mem_model (
  input wire logic clk_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [256];
  // Data stands only while rd_en_i is high; otherwise the inverse shows, so a sample outside it never matches
  assign rd_data_o = rd_en_i ? mem[rd_addr_i] : ~mem[rd_addr_i];
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
endmodule // ctd_mem_model

/* bench/tb_control_transfer_decoder.sv */
// Self-checking bench for the control-transfer decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_control_transfer_decoder;
  import ctd_pkg::*;
  logic clk = 1'b0, srst = 1'b1, valid = 1'b0;
  logic [7:0] op = 8'h00, o1 = 8'h00, o2 = 8'h00, acc = 8'h00, sp = 8'h00, rd_data, rd_addr, wa, wd, sp_o;
  logic [15:0] pc = 16'h0000, dp = 16'h0000, pc_o;
  logic [1:0] bank = 2'h0;
  logic ready, rd_en, wr_en, pc_we, cwe, cy, sp_we, iret, done;
  logic g_pcwe, g_cwe, g_cy, g_wr, g_spwe, g_int;
  logic [15:0] g_pc;
  logic [7:0] g_wa, g_wd, g_sp, g_ra;
  int fails = 0, total_checks = 0, lat;
  control_transfer_decoder i_control_transfer_decoder (.core_clk_i(clk), .srst_i(srst), .instr_valid_i(valid),
    .opcode_i(op), .operand1_i(o1), .operand2_i(o2), .pc_i(pc), .acc_i(acc), .data_pointer_i(dp), .sp_i(sp),
    .bank_i(bank), .rd_data_i(rd_data), .instr_ready_o(ready), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .wr_en_o(wr_en), .wr_addr_o(wa), .wr_data_o(wd), .pc_we_o(pc_we), .pc_o(pc_o), .carry_we_o(cwe),
    .carry_o(cy), .sp_we_o(sp_we), .sp_o(sp_o), .interrupt_return_o(iret), .done_o(done));
  ctd_mem_model i_ctd_mem_model (.clk_i(clk), .rd_en_i(rd_en), .rd_addr_i(rd_addr), .wr_en_i(wr_en),
    .wr_addr_i(wa), .wr_data_i(wd), .rd_data_o(rd_data));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One instruction: offered at a falling edge, outputs captured in the done cycle
  task automatic run(input logic [7:0] p_op, p1, p2, input logic [15:0] p_pc, input logic [7:0] p_acc,
                     input logic [15:0] p_dp, input logic [7:0] p_sp, input logic [1:0] p_bk);
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(negedge clk);
    op = p_op; o1 = p1; o2 = p2; pc = p_pc; acc = p_acc; dp = p_dp; sp = p_sp; bank = p_bk;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    g_ra = rd_addr;
    // Counts edges from the taking edge through the one that raises done_o
    lat = 1;
    while (done !== 1'b1 && lat < 12) begin
      @(negedge clk);
      lat++;
      if (rd_en === 1'b1 && lat == 2) g_ra = rd_addr;
    end
    g_pcwe = pc_we; g_pc = pc_o; g_cwe = cwe; g_cy = cy; g_wr = wr_en; g_wa = wa; g_wd = wd;
    g_spwe = sp_we; g_sp = sp_o; g_int = iret;
  endtask
  task automatic t_jumps();
    run(8'hA1, 8'h34, 8'h00, 16'h1234, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("abs pc", 16'h1534, g_pc)
    `CHK("abs lat", 2, lat)
    run(8'hA1, 8'h34, 8'h00, 16'h07FE, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("abs page", 16'h0D34, g_pc)
    run(8'h02, 8'hAB, 8'hCD, 16'h0000, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("long pc", 16'hABCD, g_pc)
    run(8'h80, 8'hFE, 8'h00, 16'h0100, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("short back", 16'h0100, g_pc)
    run(8'h80, 8'h7F, 8'h00, 16'hFFF0, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("short wrap", 16'h0071, g_pc)
    run(8'h73, 8'h00, 8'h00, 16'h0000, 8'hFF, 16'hFFF0, 8'h00, 2'h0);
    `CHK("ind pc", 16'h00EF, g_pc)
    `CHK("ind carry", 1'b0, g_cwe)
    run(8'h60, 8'h10, 8'h00, 16'h0200, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("zero taken", 16'h0212, g_pc)
    run(8'h60, 8'h10, 8'h00, 16'h0200, 8'h01, 16'h0000, 8'h00, 2'h0);
    `CHK("zero not", 16'h0202, g_pc)
    run(8'h00, 8'h00, 8'h00, 16'h0300, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("unknown pc_we", 1'b0, g_pcwe)
  endtask
  task automatic t_cbu_imm();
    run(8'hB4, 8'h20, 8'hF0, 16'h1000, 8'h10, 16'h0000, 8'h00, 2'h0);
    `CHK("imm lt pc", 16'h0FF3, g_pc)
    `CHK("imm lt c", 1'b1, g_cy)
    run(8'hB4, 8'h20, 8'hF0, 16'h1000, 8'h20, 16'h0000, 8'h00, 2'h0);
    `CHK("imm eq pc", 16'h1003, g_pc)
    `CHK("imm eq c", 1'b0, g_cy)
    run(8'hB4, 8'h20, 8'hF0, 16'h1000, 8'h30, 16'h0000, 8'h00, 2'h0);
    `CHK("imm gt pc", 16'h0FF3, g_pc)
    `CHK("imm gt c", 1'b0, g_cy)
  endtask
  task automatic t_cbu_mem();
    i_ctd_mem_model.mem[8'h40] = 8'h80;
    run(8'hB5, 8'h40, 8'h05, 16'h2000, 8'h80, 16'h0000, 8'h00, 2'h0);
    `CHK("dir eq pc", 16'h2003, g_pc)
    `CHK("dir addr", 8'h40, g_ra)
    `CHK("dir lat", 3, lat)
    run(8'hB5, 8'h40, 8'h05, 16'h2000, 8'h7F, 16'h0000, 8'h00, 2'h0);
    `CHK("dir lt c", 1'b1, g_cy)
    `CHK("dir lt pc", 16'h2008, g_pc)
    i_ctd_mem_model.mem[8'h11] = 8'h50;
    i_ctd_mem_model.mem[8'h50] = 8'h07;
    run(8'hB7, 8'h08, 8'h02, 16'h3000, 8'h00, 16'h0000, 8'h00, 2'h2);
    `CHK("ind pc", 16'h3005, g_pc)
    `CHK("ind c", 1'b1, g_cy)
    `CHK("ind lat", 4, lat)
    `CHK("ind ptr addr", 8'h50, g_ra)
    i_ctd_mem_model.mem[8'h0F] = 8'hFF;
    run(8'hBF, 8'h00, 8'h80, 16'h4000, 8'h00, 16'h0000, 8'h00, 2'h1);
    `CHK("reg pc", 16'h3F83, g_pc)
    `CHK("reg c", 1'b0, g_cy)
    `CHK("reg cwe", 1'b1, g_cwe)
  endtask
  task automatic t_dbnz();
    i_ctd_mem_model.mem[8'h03] = 8'h01;
    run(8'hDB, 8'h10, 8'h00, 16'h5000, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("reg zero pc", 16'h5002, g_pc)
    `CHK("reg wa", 8'h03, g_wa)
    `CHK("reg wd", 8'h00, g_wd)
    run(8'hDB, 8'h10, 8'h00, 16'h5000, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("reg wrap pc", 16'h5012, g_pc)
    `CHK("reg wrap wd", 8'hFF, g_wd)
    i_ctd_mem_model.mem[8'h60] = 8'h02;
    run(8'hD5, 8'h60, 8'hFC, 16'h6000, 8'h00, 16'h0000, 8'h00, 2'h0);
    `CHK("dir pc", 16'h5FFF, g_pc)
    `CHK("dir wr", 1'b1, g_wr)
    `CHK("dir wa", 8'h60, g_wa)
    `CHK("dir wd", 8'h01, g_wd)
  endtask
  task automatic t_iret();
    i_ctd_mem_model.mem[8'h09] = 8'h12;
    i_ctd_mem_model.mem[8'h08] = 8'h34;
    run(8'h32, 8'h00, 8'h00, 16'h0000, 8'h00, 16'h0000, 8'h09, 2'h0);
    `CHK("iret pc", 16'h1234, g_pc)
    `CHK("iret sp", 8'h07, g_sp)
    `CHK("iret int", 1'b1, g_int)
    `CHK("iret lat", 4, lat)
    `CHK("iret spwe", 1'b1, g_spwe)
  endtask
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_jumps();
    t_cbu_imm();
    t_cbu_mem();
    t_dbnz();
    t_iret();
    test_done();
  end
  // Whole run is under a hundred cycles; the limit leaves a wide margin
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule // tb_control_transfer_decoder

/* design/control_transfer_decoder.sv */
// Control-transfer instruction decoder and executor
`timescale 1ns/1ps
module control_transfer_decoder
  import ctd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand1_i,
  input wire logic [7:0] operand2_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [7:0] sp_i,
  input wire logic [1:0] bank_i,
  input wire logic [7:0] rd_data_i,
  output logic instr_ready_o,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic pc_we_o,
  output logic [15:0] pc_o,
  output logic carry_we_o,
  output logic carry_o,
  output logic sp_we_o,
  output logic [7:0] sp_o,
  output logic interrupt_return_o,
  output logic done_o
);
  ctd_if bus ();
  opcode_decode u_dec (.d(bus.dec));
  pc_target u_tgt (.t(bus.tgt));

  st_t st;
  st_t next_st;
  cls_t cls_q;
  logic [1:0] len_q;
  logic [7:0] op_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic [15:0] pc_q;
  logic [7:0] acc_q;
  logic [15:0] dp_q;
  logic [7:0] sp_q;
  logic [7:0] opnd;
  logic [7:0] pop_hi;

  wire logic accept = instr_ready_o & instr_valid_i;
  wire cls_t dcls = bus.cls;
  wire logic [2:0] reg_sel = (dcls == CLS_CBU_IND) ? {2'b00, opcode_i[0]} : opcode_i[2:0];
  wire logic [7:0] reg_addr = {3'b000, bank_i, reg_sel};
  wire logic d_direct = (dcls == CLS_CBU_DIR) || (dcls == CLS_DBNZ_DIR);
  wire logic d_reg = (dcls == CLS_CBU_REG) || (dcls == CLS_DBNZ_REG);

  assign bus.op = opcode_i;
  assign bus.pc = pc_q;
  assign bus.step = len_q;

  wire logic is_cbu = (cls_q == CLS_CBU_IMM) || (cls_q == CLS_CBU_DIR) ||
                      (cls_q == CLS_CBU_IND) || (cls_q == CLS_CBU_REG);
  wire logic three_rel = is_cbu || (cls_q == CLS_DBNZ_DIR);
  assign bus.off = three_rel ? b2_q : b1_q;

  // Register forms compare the fetched byte; accumulator forms compare acc
  wire logic first_mem = (cls_q == CLS_CBU_IND) || (cls_q == CLS_CBU_REG);
  wire logic second_imm = (cls_q == CLS_CBU_IMM) || first_mem;
  wire logic [7:0] first = first_mem ? opnd : acc_q;
  wire logic [7:0] second = second_imm ? b1_q : opnd;
  wire logic ne = (first != second);
  wire logic lt = (first < second);
  wire logic [7:0] dec_val = opnd - 8'h01;
  wire logic is_dbnz = (cls_q == CLS_DBNZ_REG) || (cls_q == CLS_DBNZ_DIR);

  wire logic take = is_cbu ? ne :
                    is_dbnz ? (dec_val != RST_BYTE) :
                    (cls_q == CLS_ACC_ZERO) ? (acc_q == RST_BYTE) :
                    (cls_q == CLS_SHORT);

  wire logic [15:0] ind_target = acc_q + dp_q;
  wire logic [15:0] next_pc = (cls_q == CLS_ABS) ? {bus.seq[15:11], op_q[7:5], b1_q} :
                              (cls_q == CLS_LONG) ? {b1_q, b2_q} :
                              (cls_q == CLS_IND) ? ind_target :
                              (cls_q == CLS_IRET) ? {pop_hi, opnd} :
                              take ? bus.rel : bus.seq;

  always_comb begin
    next_st = st;
    unique case (st)
      S_IDLE: begin
        if (accept) begin
          if (dcls == CLS_CBU_IND) begin
            next_st = S_PTR;
          end else if (d_direct || d_reg) begin
            next_st = S_OPND;
          end else if (dcls == CLS_IRET) begin
            next_st = S_POP_HI;
          end else begin
            next_st = S_EXEC;
          end
        end
      end
      S_PTR: next_st = S_OPND;
      S_OPND: next_st = S_EXEC;
      S_POP_HI: next_st = S_POP_LO;
      S_POP_LO: next_st = S_EXEC;
      S_EXEC: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Instruction and datapath snapshot, held until the next acceptance
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cls_q <= CLS_NONE;
      len_q <= LEN_1;
      op_q <= RST_BYTE;
      b1_q <= RST_BYTE;
      b2_q <= RST_BYTE;
      pc_q <= RST_WORD;
      acc_q <= RST_BYTE;
      dp_q <= RST_WORD;
      sp_q <= RST_BYTE;
    end else if (accept) begin
      cls_q <= dcls;
      len_q <= bus.len;
      op_q <= opcode_i;
      b1_q <= operand1_i;
      b2_q <= operand2_i;
      pc_q <= pc_i;
      acc_q <= acc_i;
      dp_q <= data_pointer_i;
      sp_q <= sp_i;
    end
  end

  // Read port: rd_data_i is taken at the edge that ends each rd_en_o cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_en_o <= 1'b0;
      rd_addr_o <= RST_BYTE;
    end else begin
      rd_en_o <= 1'b0;
      if (accept && (dcls == CLS_CBU_IND || d_reg)) begin
        rd_en_o <= 1'b1;
        rd_addr_o <= reg_addr;
      end else if (accept && d_direct) begin
        rd_en_o <= 1'b1;
        rd_addr_o <= operand1_i;
      end else if (accept && dcls == CLS_IRET) begin
        rd_en_o <= 1'b1;
        rd_addr_o <= sp_i;
      end else if (st == S_PTR) begin
        rd_en_o <= 1'b1;
        rd_addr_o <= rd_data_i;
      end else if (st == S_POP_HI) begin
        rd_en_o <= 1'b1;
        rd_addr_o <= sp_q - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      opnd <= RST_BYTE;
      pop_hi <= RST_BYTE;
    end else if (st == S_OPND || st == S_POP_LO) begin
      opnd <= rd_data_i;
    end else if (st == S_POP_HI) begin
      pop_hi <= rd_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      instr_ready_o <= 1'b0;
    end else begin
      instr_ready_o <= (next_st == S_IDLE) && !accept;
    end
  end

  // One-cycle result pulses; unknown opcodes only raise done_o
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pc_we_o <= 1'b0;
      pc_o <= RST_WORD;
      carry_we_o <= 1'b0;
      carry_o <= 1'b0;
      wr_en_o <= 1'b0;
      wr_addr_o <= RST_BYTE;
      wr_data_o <= RST_BYTE;
      sp_we_o <= 1'b0;
      sp_o <= RST_BYTE;
      interrupt_return_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      pc_we_o <= 1'b0;
      carry_we_o <= 1'b0;
      wr_en_o <= 1'b0;
      sp_we_o <= 1'b0;
      interrupt_return_o <= 1'b0;
      done_o <= (st == S_EXEC);
      if (st == S_EXEC && cls_q != CLS_NONE) begin
        pc_we_o <= 1'b1;
        pc_o <= next_pc;
        carry_we_o <= is_cbu;
        carry_o <= lt;
        wr_en_o <= is_dbnz;
        wr_addr_o <= rd_addr_o;
        wr_data_o <= dec_val;
        sp_we_o <= (cls_q == CLS_IRET);
        sp_o <= sp_q - 8'h02;
        interrupt_return_o <= (cls_q == CLS_IRET);
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_abs_target;
    done_o && pc_we_o && cls_q == CLS_ABS |->
      pc_o == {pc_q[15:11] + {4'h0, (pc_q[10:0] > 11'h7FD)}, op_q[7:5], b1_q};
  endproperty
  a_abs_target: assert property (p_abs_target) else $error("absolute jump target wrong");

  property p_long_target;
    done_o && cls_q == CLS_LONG |-> pc_we_o && pc_o == {b1_q, b2_q};
  endproperty
  a_long_target: assert property (p_long_target) else $error("long jump target wrong");

  property p_short_target;
    done_o && cls_q == CLS_SHORT |-> pc_o == pc_q + 16'h0002 + {{8{b1_q[7]}}, b1_q};
  endproperty
  a_short_target: assert property (p_short_target) else $error("short jump target wrong");

  property p_cbu_imm_timing;
    accept && opcode_i == OPC_CBU_IMM |-> ##2 done_o && pc_we_o && carry_we_o;
  endproperty
  a_cbu_imm_timing: assert property (p_cbu_imm_timing) else $error("immediate compare not done in two cycles");

  property p_cbu_fall;
    done_o && is_cbu && first == second |-> pc_o == pc_q + 16'h0003;
  endproperty
  a_cbu_fall: assert property (p_cbu_fall) else $error("equal compare must step by three");

  property p_cbu_carry;
    done_o && is_cbu |-> carry_we_o && carry_o == (first < second) && $past(st) == S_EXEC;
  endproperty
  a_cbu_carry: assert property (p_cbu_carry) else $error("compare carry wrong");

  property p_dbnz_reg;
    done_o && cls_q == CLS_DBNZ_REG |->
      wr_en_o && wr_addr_o[7:3] == {3'b000, bank_i} && wr_data_o == opnd - 8'h01 &&
      pc_o == ((opnd == 8'h01) ? pc_q + 16'h0002 : pc_q + 16'h0002 + {{8{b1_q[7]}}, b1_q});
  endproperty
  a_dbnz_reg: assert property (p_dbnz_reg) else $error("register decrement branch wrong");

  property p_dbnz_dir;
    accept && opcode_i == OPC_DBNZ_DIR ##3 done_o |->
      wr_en_o && wr_addr_o == b1_q && (opnd != 8'h01 || pc_o == pc_q + 16'h0003);
  endproperty
  a_dbnz_dir: assert property (p_dbnz_dir) else $error("direct decrement branch wrong");

  property p_zero_skip;
    done_o && cls_q == CLS_ACC_ZERO && acc_q != 8'h00 |-> pc_o == pc_q + 16'h0002 && !carry_we_o;
  endproperty
  a_zero_skip: assert property (p_zero_skip) else $error("jump if zero taken on non-zero");

  property p_zero_taken;
    done_o && cls_q == CLS_ACC_ZERO && acc_q == 8'h00 |-> pc_o == pc_q + 16'h0002 + {{8{b1_q[7]}}, b1_q};
  endproperty
  a_zero_taken: assert property (p_zero_taken) else $error("jump if zero not taken on zero");

  property p_cbu_imm_offset;
    done_o && cls_q == CLS_CBU_IMM && acc_q != b1_q |-> pc_o == pc_q + 16'h0003 + {{8{b2_q[7]}}, b2_q};
  endproperty
  a_cbu_imm_offset: assert property (p_cbu_imm_offset) else $error("immediate compare offset wrong");

  property p_ind_jump;
    done_o && cls_q == CLS_IND |-> pc_o == acc_q + dp_q && !carry_we_o && !wr_en_o;
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("indirect jump target wrong");
endmodule // control_transfer_decoder

/* design/ctd_if.sv */
// Decode and target-adder signals between the decoder's own modules
`timescale 1ns/1ps
interface ctd_if;
  import ctd_pkg::*;
  logic [7:0] op;
  cls_t cls;
  logic [1:0] len;
  // Held length of the accepted instruction; kept apart from len, which the classifier drives live
  logic [1:0] step;
  logic [15:0] pc;
  logic [7:0] off;
  logic [15:0] seq;
  logic [15:0] rel;
  modport dec (input op, output cls, output len);
  modport tgt (input pc, input step, input off, output seq, output rel);
  modport core (output op, input cls, input len, output step, output pc, output off, input seq, input rel);
endinterface

/* design/ctd_pkg.sv */
// Opcodes, lengths and types shared by the control-transfer decoder files
package ctd_pkg;
  localparam logic [4:0] OPC_ABS_LOW = 5'h01;
  localparam logic [7:0] OPC_LONG = 8'h02;
  localparam logic [7:0] OPC_SHORT = 8'h80;
  localparam logic [7:0] OPC_IND = 8'h73;
  localparam logic [7:0] OPC_IRET = 8'h32;
  localparam logic [7:0] OPC_ACC_ZERO = 8'h60;
  localparam logic [7:0] OPC_CBU_IMM = 8'hB4;
  localparam logic [7:0] OPC_CBU_DIR = 8'hB5;
  localparam logic [6:0] OPC_CBU_IND_HI = 7'h5B;
  localparam logic [4:0] OPC_CBU_REG_HI = 5'h17;
  localparam logic [4:0] OPC_DBNZ_REG_HI = 5'h1B;
  localparam logic [7:0] OPC_DBNZ_DIR = 8'hD5;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [3:0] {
    CLS_NONE, CLS_ABS, CLS_LONG, CLS_SHORT, CLS_IND, CLS_CBU_IMM, CLS_CBU_DIR,
    CLS_CBU_IND, CLS_CBU_REG, CLS_DBNZ_REG, CLS_DBNZ_DIR, CLS_ACC_ZERO, CLS_IRET
  } cls_t;

  typedef enum logic [2:0] {S_IDLE, S_PTR, S_OPND, S_POP_HI, S_POP_LO, S_EXEC} st_t;
endpackage

/* design/opcode_decode.sv */
// Opcode classifier for the control-transfer group
`timescale 1ns/1ps
module opcode_decode
  import ctd_pkg::*;
(
  ctd_if.dec d
);
  // Bit 7 is the most significant opcode bit in every match below except is_abs, which looks at bits 4:0 only
  wire logic is_abs = (d.op[4:0] == OPC_ABS_LOW);
  wire logic is_cbu_ind = (d.op[7:1] == OPC_CBU_IND_HI);
  wire logic is_cbu_reg = (d.op[7:3] == OPC_CBU_REG_HI);
  wire logic is_dbnz_reg = (d.op[7:3] == OPC_DBNZ_REG_HI);

  assign d.cls = is_abs ? CLS_ABS :
                 (d.op == OPC_LONG) ? CLS_LONG :
                 (d.op == OPC_SHORT) ? CLS_SHORT :
                 (d.op == OPC_IND) ? CLS_IND :
                 (d.op == OPC_CBU_IMM) ? CLS_CBU_IMM :
                 (d.op == OPC_CBU_DIR) ? CLS_CBU_DIR :
                 is_cbu_ind ? CLS_CBU_IND :
                 is_cbu_reg ? CLS_CBU_REG :
                 is_dbnz_reg ? CLS_DBNZ_REG :
                 (d.op == OPC_DBNZ_DIR) ? CLS_DBNZ_DIR :
                 (d.op == OPC_ACC_ZERO) ? CLS_ACC_ZERO :
                 (d.op == OPC_IRET) ? CLS_IRET : CLS_NONE;

  assign d.len = (d.cls == CLS_IND || d.cls == CLS_IRET || d.cls == CLS_NONE) ? LEN_1 :
                 (d.cls == CLS_LONG || d.cls == CLS_CBU_IMM || d.cls == CLS_CBU_DIR ||
                  d.cls == CLS_CBU_IND || d.cls == CLS_CBU_REG || d.cls == CLS_DBNZ_DIR) ? LEN_3 : LEN_2;
endmodule // opcode_decode

/* design/pc_target.sv */
// Sequential and relative program-counter targets
`timescale 1ns/1ps
module pc_target
  import ctd_pkg::*;
(
  ctd_if.tgt t
);
  // Relative offset is signed and applies after the instruction length
  assign t.seq = t.pc + {14'h0000, t.step};
  assign t.rel = t.seq + {{8{t.off[7]}}, t.off};
endmodule // pc_target
